/* File: mbs_pkg.sv */
package mbs_pkg;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE_ONE = 8'h06;
  localparam logic [7:0] FN_LOOP = 8'h08;
  localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0] DIAG_RETURN = 8'h00;
  localparam logic [7:0] MAX_WORDS = 8'h20;
  localparam int HDR_LEN = 6;
  localparam int FRAME_MAX = 80;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h01;

  // receive byte stream; eof comes with the last byte of a frame
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic eof;
  } mbs_rx_t;

  // transmit byte stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } mbs_tx_t;

  // holding word port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbs_word_t;

  typedef enum logic [2:0] {
    ST_RX = 3'b000,
    ST_CHECK = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b011,
    ST_TX = 3'b100
  } mbs_state_t;
endpackage

/* File: mbs_crc.sv */
`timescale 1ns/1ps
module mbs_crc (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // control
  input wire logic i_clear,
  input wire logic i_en,
  input wire logic [7:0] i_data,
  // result
  output logic [15:0] o_crc
);
  typedef struct packed {
    logic [15:0] crc;
  } mbs_crc_st_t;
  mbs_crc_st_t s_r;
  mbs_crc_st_t s_nxt;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ mbs_pkg::CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  always_comb begin
    s_nxt = s_r;
    if (i_clear) begin
      s_nxt.crc = mbs_pkg::CRC_INIT;
    end else if (i_en) begin
      s_nxt.crc = crc_byte(s_r.crc, i_data);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r <= '{crc: mbs_pkg::CRC_INIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_crc = s_r.crc;
endmodule

/* File: mbs_slave.sv */
`timescale 1ns/1ps
// How it works
// RQ1 - read reply: address, function, byte count, words high byte first, CRC
// RQ2 - master asks at most 32 words per read; larger requests are dropped
// RQ3 - word numbers are relative offsets from start of word space
// RQ4 - single write request: addr, 06, word number, value, CRC
// RQ5 - single write reply echoes the received request unchanged
// RQ6 - function 08 loop-back diagnostic is served
// RQ7 - loop-back request carries diagnostic 00 00 and arbitrary data
// RQ8 - loop-back reply keeps request order; code 00 00 returns request
// RQ9 - multi write request: addr, 10h, start, count, byte count, data
// RQ10 - multi write stores words at consecutive addresses from start
// RQ11 - multi write reply: addr, 10h, start, count, CRC, no data
// RQ12 - master writes at most 32 words per multi write
// RQ13 - read request: addr, 03, start, count, each high byte first, CRC
// RQ14 - CRC-16 is checked on receive and appended on send; bad frames dropped
module mbs_slave (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // configuration
  input wire logic [7:0] i_slave_addr,
  // receive stream
  input wire mbs_pkg::mbs_rx_t i_rx,
  // transmit stream
  output mbs_pkg::mbs_tx_t o_tx,
  input wire logic i_tx_ready,
  // holding word port, read data valid in the same cycle as o_word.rd
  output mbs_pkg::mbs_word_t o_word,
  input wire logic [15:0] i_word_rdata,
  // status
  output logic o_frame_drop
);
  typedef struct packed {
    mbs_pkg::mbs_state_t st;
    logic [6:0] len;
    logic [6:0] idx;
    logic [5:0] cnt;
    logic [5:0] total;
    logic [15:0] addr;
    logic tx_crc;
    logic [1:0] crc_ph;
    mbs_pkg::mbs_tx_t tx;
    mbs_pkg::mbs_word_t word;
    logic drop;
    logic rd_pend;
  } mbs_st_t;

  mbs_st_t s_r;
  mbs_st_t s_nxt;
  logic [7:0] buf_r [mbs_pkg::FRAME_MAX];
  logic buf_we;
  logic [6:0] buf_wa;
  logic [7:0] buf_wd;
  logic crc_clear;
  logic crc_en;
  logic [7:0] crc_data;
  logic [15:0] crc_val;

  function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  mbs_crc u_crc (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_clear(crc_clear),
    .i_en(crc_en),
    .i_data(crc_data),
    .o_crc(crc_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] fn;
    logic [15:0] nwords;
    logic ok;
    logic tx_go;
    fn = buf_r[1];
    nwords = be16(buf_r[4], buf_r[5]);
    ok = 1'b0;
    tx_go = 1'b0;
    s_nxt = s_r;
    s_nxt.word.rd = 1'b0;
    s_nxt.word.wr = 1'b0;
    s_nxt.drop = 1'b0;
    buf_we = 1'b0;
    buf_wa = s_r.len;
    buf_wd = i_rx.data;
    crc_clear = 1'b0;
    crc_en = 1'b0;
    crc_data = i_rx.data;
    if (s_r.tx.valid && i_tx_ready) begin
      s_nxt.tx.valid = 1'b0;
    end
    case (s_r.st)
      mbs_pkg::ST_RX: begin
        if (i_rx.valid) begin
          crc_en = 1'b1;
          if (s_r.len < 7'(mbs_pkg::FRAME_MAX)) begin
            buf_we = 1'b1;
            s_nxt.len = s_r.len + 7'd1;
          end
          if (i_rx.eof) begin
            s_nxt.st = mbs_pkg::ST_CHECK;
          end
        end
      end
      mbs_pkg::ST_CHECK: begin
        // crc over data plus its own low-first crc leaves zero
        if (crc_val == 16'h0000 && s_r.len >= 7'd8 && buf_r[0] == i_slave_addr) begin // RQ14
          case (fn)
            mbs_pkg::FN_READ: ok = s_r.len == 7'd8 && nwords != 16'h0000
                && nwords <= 16'(mbs_pkg::MAX_WORDS); // RQ2 RQ13
            mbs_pkg::FN_WRITE_ONE: ok = s_r.len == 7'd8; // RQ4
            mbs_pkg::FN_LOOP: ok = s_r.len == 7'd8 && buf_r[2] == mbs_pkg::DIAG_RETURN
                && buf_r[3] == mbs_pkg::DIAG_RETURN; // RQ6 RQ7
            mbs_pkg::FN_WRITE_MULTI: ok = nwords != 16'h0000
                && nwords <= 16'(mbs_pkg::MAX_WORDS) && buf_r[6] == 8'(nwords << 1)
                && s_r.len == 7'(9 + 2 * nwords); // RQ9 RQ12
            default: ok = 1'b0;
          endcase
        end
        s_nxt.addr = be16(buf_r[2], buf_r[3]); // RQ3
        s_nxt.total = nwords[5:0];
        s_nxt.idx = 7'd0;
        s_nxt.cnt = 6'd0;
        s_nxt.len = 7'd0;
        crc_clear = 1'b1;
        if (!ok) begin
          s_nxt.drop = 1'b1; // RQ14
          s_nxt.st = mbs_pkg::ST_RX;
        end else if (fn == mbs_pkg::FN_READ) begin
          s_nxt.st = mbs_pkg::ST_READ;
        end else if (fn == mbs_pkg::FN_LOOP) begin
          s_nxt.len = 7'd6; // RQ8
          s_nxt.st = mbs_pkg::ST_TX;
        end else begin
          s_nxt.st = mbs_pkg::ST_WRITE;
        end
      end
      mbs_pkg::ST_WRITE: begin
        s_nxt.word.wr = 1'b1;
        s_nxt.word.addr = s_r.addr + 16'(s_r.cnt); // RQ10
        if (fn == mbs_pkg::FN_WRITE_ONE) begin
          s_nxt.word.wdata = be16(buf_r[4], buf_r[5]);
          s_nxt.len = 7'd6; // RQ5
          s_nxt.st = mbs_pkg::ST_TX;
        end else begin
          s_nxt.word.wdata = be16(buf_r[7'(7 + 2 * s_r.cnt)],
              buf_r[7'(8 + 2 * s_r.cnt)]); // RQ10
          s_nxt.cnt = s_r.cnt + 6'd1;
          if (16'(s_r.cnt) + 16'd1 == nwords) begin
            s_nxt.len = 7'd6; // RQ11
            s_nxt.st = mbs_pkg::ST_TX;
          end
        end
      end
      mbs_pkg::ST_READ: begin
        // the reply overwrites the request in place, so the word count lives in state
        s_nxt.rd_pend = 1'b0;
        if (s_r.rd_pend) begin
          buf_we = 1'b1;
          buf_wa = 7'(3 + 2 * (s_r.cnt - 6'd1));
          buf_wd = i_word_rdata[15:8]; // RQ1
        end
        if (s_r.cnt < s_r.total) begin
          s_nxt.word.rd = 1'b1;
          s_nxt.word.addr = s_r.addr + 16'(s_r.cnt); // RQ3
          s_nxt.rd_pend = 1'b1;
          s_nxt.cnt = s_r.cnt + 6'd1;
        end else if (!s_r.rd_pend) begin
          s_nxt.len = 7'(3 + 2 * s_r.total);
          s_nxt.st = mbs_pkg::ST_TX;
        end
      end
      mbs_pkg::ST_TX: begin
        tx_go = !s_r.tx.valid || i_tx_ready;
        if (tx_go) begin
          s_nxt.tx.valid = 1'b1;
          s_nxt.tx.last = 1'b0;
          if (!s_r.tx_crc) begin
            s_nxt.tx.data = (fn == mbs_pkg::FN_READ && s_r.idx == 7'd2)
                ? {1'b0, s_r.total, 1'b0} : buf_r[s_r.idx]; // RQ1
            crc_en = 1'b1;
            crc_data = s_nxt.tx.data;
            s_nxt.idx = s_r.idx + 7'd1;
            if (s_r.idx + 7'd1 == s_r.len) begin
              s_nxt.tx_crc = 1'b1;
              s_nxt.crc_ph = 2'd0;
            end
          end else if (s_r.crc_ph == 2'd0) begin
            s_nxt.tx.data = crc_val[7:0]; // RQ14
            s_nxt.crc_ph = 2'd1;
          end else begin
            s_nxt.tx.data = crc_val[15:8];
            s_nxt.tx.last = 1'b1;
            s_nxt.tx_crc = 1'b0;
            s_nxt.len = 7'd0;
            crc_clear = 1'b1;
            s_nxt.st = mbs_pkg::ST_RX;
          end
        end
      end
      default: s_nxt.st = mbs_pkg::ST_RX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // both bytes of a read word land together, so the next word cannot step on the low one
  logic lo_we;
  logic [6:0] lo_wa;

  assign lo_we = (s_r.st == mbs_pkg::ST_READ) && s_r.rd_pend;
  assign lo_wa = buf_wa + 7'd1;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (buf_we) begin
      buf_r[buf_wa] <= buf_wd;
    end
    if (lo_we) begin
      buf_r[lo_wa] <= i_word_rdata[7:0]; // RQ1
    end
  end

  assign o_tx = s_r.tx;
  assign o_word = s_r.word;
  assign o_frame_drop = s_r.drop;
endmodule

/* File: mbs_slave_properties.sv */
`timescale 1ns/1ps
module mbs_slave_properties (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire mbs_pkg::mbs_tx_t o_tx,
  input wire logic i_tx_ready,
  input wire mbs_pkg::mbs_word_t o_word,
  input wire logic o_frame_drop
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  AST_TX_HOLD: assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx))
    else $error("tx byte moved before accept");
  AST_LAST_END: assert property (o_tx.valid && o_tx.last && i_tx_ready |=> !o_tx.valid[*2])
    else $error("tx continues after last");
  AST_DROP_PULSE: assert property (o_frame_drop |=> !o_frame_drop)
    else $error("drop longer than one cycle");
  AST_DROP_QUIET: assert property (o_frame_drop |-> !o_word.wr ##1 !o_tx.valid[*8])
    else $error("dropped frame answered");
  AST_WR_CONSEC: assert property (o_word.wr && $past(o_word.wr)
    |-> o_word.addr == $past(o_word.addr) + 16'h0001)
    else $error("write address not consecutive");
  AST_RD_CONSEC: assert property (o_word.rd && $past(o_word.rd)
    |-> o_word.addr == $past(o_word.addr) + 16'h0001)
    else $error("read address not consecutive");
  AST_WR_NO_TX: assert property (o_word.wr || o_word.rd |-> !o_tx.valid)
    else $error("reply overlaps word access");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    i_reset |=> !o_tx.valid && !o_word.wr && !o_word.rd && !o_frame_drop)
    else $error("outputs active after reset");
endmodule

/* File: mbs_master.sv */
`timescale 1ns/1ps
module mbs_master (
  input wire logic i_clk_sys,
  input wire logic i_slow,
  input wire mbs_pkg::mbs_tx_t i_tx,
  output logic o_ready
);
  logic [8:0] q[$];
  initial o_ready = 1'b0;
  // slow mode stalls at random so the reply must hold each byte
  always @(posedge i_clk_sys) begin
    if (i_tx.valid === 1'b1 && o_ready) q.push_back({i_tx.last, i_tx.data});
    o_ready <= !i_slow || ($urandom % 3 == 0);
  end
endmodule

/* File: tb_mbs_slave.sv */
`timescale 1ns/1ps
module tb_mbs_slave;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic rdy;
  logic drop;
  logic [15:0] rdata;
  mbs_pkg::mbs_rx_t rx = '0;
  mbs_pkg::mbs_tx_t tx;
  mbs_pkg::mbs_word_t wd;
  logic [7:0] fr[$];
  logic [15:0] wq[$];
  logic [15:0] ew[$];
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int rds = 0;
  int drops = 0;
  always #10 clk = ~clk;
  mbs_slave u_mbs_slave (.i_clk_sys(clk), .i_reset(rst), .i_slave_addr(8'h5A), .i_rx(rx),
    .o_tx(tx), .i_tx_ready(rdy), .o_word(wd), .i_word_rdata(rdata), .o_frame_drop(drop));
  mbs_master u_mbs_master (.i_clk_sys(clk), .i_slow(slow), .i_tx(tx), .o_ready(rdy));
  // word store reads straight from the strobed address; the slave takes it in that cycle
  always_comb rdata = wd.addr ^ 16'hA5C3;
  always @(posedge clk) begin
    if (wd.wr === 1'b1) wq.push_back(wd.addr);
    if (wd.wr === 1'b1) wq.push_back(wd.wdata);
    rds += (wd.rd === 1'b1);
    drops += (drop === 1'b1);
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (e !== g) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic run(input logic [7:0] ex[$], input int nrd, input bit bad);
    logic [15:0] c;
    int n;
    c = crc(fr) ^ {15'h0000, bad};
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    foreach (fr[i]) begin
      rx <= '{1'b1, fr[i], i == fr.size() - 1};
      @(posedge clk);
    end
    rx <= '0;
    c = crc(ex);
    if (ex.size() > 0) ex = {ex, c[7:0], c[15:8]};
    for (n = 0; n < 600 && drops == 0 && u_mbs_master.q.size() < ex.size(); n++) @(posedge clk);
    repeat (12) @(posedge clk);
    chk("reply length", ex.size(), u_mbs_master.q.size());
    chk("frame drop", ex.size() == 0, drops);
    chk("reads", nrd, rds);
    chk("writes", ew.size(), wq.size());
    foreach (ex[i]) if (i < u_mbs_master.q.size())
      chk("reply byte", {i == ex.size() - 1, ex[i]}, u_mbs_master.q[i]);
    foreach (ew[i]) if (i < wq.size()) chk("word write", ew[i], wq[i]);
    u_mbs_master.q.delete();
    wq.delete();
    ew.delete();
    fr.delete();
    rds = 0;
    drops = 0;
  endtask
  task automatic scen(input int op, input int n);
    logic [15:0] a;
    logic [15:0] v;
    logic [7:0] ex[$];
    a = $urandom;
    v = $urandom;
    case (op)
      1, 7: fr = {8'h5A, 8'h08, 8'h00, op == 7 ? 8'h01 : 8'h00, v[15:8], v[7:0]};
      2, 4: fr = {8'h5A, 8'h03, a[15:8], a[7:0], 8'h00, op == 4 ? 8'h21 : 8'(n)};
      3: fr = {8'h5A, 8'h10, a[15:8], a[7:0], 8'h00, 8'(n), 8'(2 * n)};
      default: fr = {op == 6 ? 8'h5B : 8'h5A, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]};
    endcase
    if (op < 4) ex = fr[0:5];
    if (op == 0) ew = {a, v};
    if (op == 2) ex = {8'h5A, 8'h03, 8'(2 * n)};
    for (int i = 0; i < n && (op == 2 || op == 3); i++) begin
      if (op == 3) begin
        v = $urandom;
        fr = {fr, v[15:8], v[7:0]};
        ew = {ew, a + i[15:0], v};
      end else begin
        v = (a + i[15:0]) ^ 16'hA5C3;
        ex = {ex, v[15:8], v[7:0]};
      end
    end
    run(ex, op == 2 ? n : 0, op == 5);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(5570));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 32; k++) begin
      slow <= k[3];
      scen(k % 8, k < 8 ? 1 : k < 16 ? 32 : 1 + $urandom % 32);
    end
    end_of_test();
  end
endmodule
bind mbs_slave mbs_slave_properties u_props (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .o_tx(o_tx), .i_tx_ready(i_tx_ready), .o_word(o_word), .o_frame_drop(o_frame_drop));
